// File: shared/cadr_pkg.sv
// Package for the codec compressor and level-control register bank
package cadr_pkg;
    // Direct byte registers; offsets are not all multiples of four, so they are indexes
    localparam logic [7:0] IDX_CMD = 8'h2F;
    localparam logic [7:0] IDX_DATA = 8'h30;
    localparam logic [7:0] IDX_LDSTAT = 8'h31;
    localparam logic [7:0] IDX_RDSTAT = 8'h32;
    localparam logic [7:0] IDX_LASTAT = 8'h33;
    localparam logic [7:0] IDX_RASTAT = 8'h34;
    localparam logic [7:0] IDX_TEST = 8'h35;
    localparam logic [7:0] IDX_DAC2_CMD = 8'h40;
    localparam logic [7:0] IDX_DAC2_DATA = 8'h41;
    localparam int ADDR_LSB = 2;

    // Indirect addresses
    localparam logic [5:0] IA_0 = 6'h00;
    localparam logic [5:0] IA_1 = 6'h01;
    localparam logic [5:0] IA_2 = 6'h02;
    localparam logic [5:0] IA_3 = 6'h03;
    localparam logic [5:0] IA_4 = 6'h04;

    // Field positions
    localparam int CMD_EN_BIT = 7;
    localparam int CMD_LOAD_BIT = 6;
    localparam int TEST_FAST_BIT = 7;

    // Writable masks: reserved bits ignore writes and read zero
    localparam logic [7:0] M_DAC2_0 = 8'h9F;
    localparam logic [7:0] M_DAC2_1 = 8'h07;
    localparam logic [7:0] M_DAC2_2 = 8'h1F;
    localparam logic [7:0] M_DAC2_3 = 8'h07;
    localparam logic [7:0] M_ADC_0 = 8'h3C;
    localparam logic [7:0] M_ADC_1 = 8'hFF;
    localparam logic [7:0] M_ADC_2 = 8'hFF;
    localparam logic [7:0] M_ADC_3 = 8'h1F;
    localparam logic [7:0] M_ADC_4 = 8'h1F;
    localparam logic [7:0] M_TEST = 8'h80;

    // Reset values
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_ADC_0 = 8'h34;
    localparam logic [7:0] RST_ADC_1 = 8'h07;
    localparam logic [7:0] RST_ADC_2 = 8'h44;
    localparam logic [7:0] RST_ADC_3 = 8'h1F;

    localparam logic [2:0] RATIO_MAX = 3'h5;

    // Decoded compressor settings per channel
    typedef struct packed {
        logic [4:0] threshold;
        logic [2:0] ratio;
    } cadr_comp_s;

    // Decoded level-control settings
    typedef struct packed {
        logic enable;
        logic [3:0] target;
        logic gate_enable;
        logic [2:0] gate_threshold;
        logic [3:0] hold;
        logic [3:0] ramp_down_interval;
        logic [3:0] ramp_up_interval;
        logic [4:0] upper_limit;
        logic [4:0] lower_limit;
    } cadr_agc_s;
endpackage

// File: hw/cadr_regs.sv
// Register bank for the second DAC compressor and the ADC level control
`timescale 1ns/100ps
module cadr_regs (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output cadr_pkg::cadr_comp_s dac2_left,
    output cadr_pkg::cadr_comp_s dac2_right,
    output cadr_pkg::cadr_agc_s adc_ctrl,
    output logic fast_startup
);
    // Direct registers: level-control command and data, compressor command and data, test
    logic [7:0] cmd;
    logic [7:0] data;
    logic [7:0] dcmd;
    logic [7:0] ddata;
    logic [7:0] test;
    logic [7:0] next_cmd;
    logic [7:0] next_data;
    logic [7:0] next_dcmd;
    logic [7:0] next_ddata;
    logic [7:0] next_test;

    // Indirect banks, addressed by the low bits of each command's address field
    logic [7:0] dac2 [0:3];
    logic [7:0] adc [0:4];
    logic [7:0] next_dac2 [0:3];
    logic [7:0] next_adc [0:4];

    // Bus answer
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;

    // Decoded settings toward the datapath
    cadr_pkg::cadr_comp_s next_left;
    cadr_pkg::cadr_comp_s next_right;
    cadr_pkg::cadr_agc_s next_ctrl;
    logic next_fast;

    // Address decode and access qualifiers
    logic [7:0] idx;
    logic acc;
    logic wr;
    logic rd;
    logic wr_en;
    logic mapped;
    logic [7:0] wbyte;
    logic [7:0] adc_sel;
    logic [7:0] dac2_sel;
    logic adc_hit;
    logic dac2_hit;
    logic adc_commit;
    logic dac2_commit;

    // Word index of the byte register; the byte-lane bits below it are ignored
    assign idx = paddr[cadr_pkg::ADDR_LSB +: 8];
    // One wait state: the access is taken in its first cycle, pready answers in the next
    assign acc = psel && penable && !pready;
    assign wr = acc && pwrite;
    assign rd = acc && !pwrite;
    // Only the low lane carries data; a write with its strobe low changes nothing
    assign wr_en = wr && pstrb[0];
    assign wbyte = pwdata[7:0];

    // Register map; any other index answers with an error and writes nothing
    always_comb begin
        case (idx)
            cadr_pkg::IDX_CMD,
            cadr_pkg::IDX_DATA,
            cadr_pkg::IDX_LDSTAT,
            cadr_pkg::IDX_RDSTAT,
            cadr_pkg::IDX_LASTAT,
            cadr_pkg::IDX_RASTAT,
            cadr_pkg::IDX_TEST,
            cadr_pkg::IDX_DAC2_CMD,
            cadr_pkg::IDX_DAC2_DATA: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // Masks for the indirect spaces
    function automatic logic [7:0] adc_mask(input logic [5:0] a);
        case (a)
            cadr_pkg::IA_0: adc_mask = cadr_pkg::M_ADC_0;
            cadr_pkg::IA_1: adc_mask = cadr_pkg::M_ADC_1;
            cadr_pkg::IA_2: adc_mask = cadr_pkg::M_ADC_2;
            cadr_pkg::IA_3: adc_mask = cadr_pkg::M_ADC_3;
            cadr_pkg::IA_4: adc_mask = cadr_pkg::M_ADC_4;
            default: adc_mask = 8'h00;
        endcase
    endfunction

    function automatic logic [7:0] dac2_mask(input logic [5:0] a);
        case (a)
            cadr_pkg::IA_0: dac2_mask = cadr_pkg::M_DAC2_0;
            cadr_pkg::IA_1: dac2_mask = cadr_pkg::M_DAC2_1;
            cadr_pkg::IA_2: dac2_mask = cadr_pkg::M_DAC2_2;
            cadr_pkg::IA_3: dac2_mask = cadr_pkg::M_DAC2_3;
            default: dac2_mask = 8'h00;
        endcase
    endfunction

    // Indirect read-back selection; unknown addresses read zero
    always_comb begin
        adc_hit = (cmd[5:0] <= cadr_pkg::IA_4);
        dac2_hit = (dcmd[5:0] <= cadr_pkg::IA_3);
        adc_sel = adc_hit ? adc[cmd[2:0]] : 8'h00;
        dac2_sel = dac2_hit ? dac2[dcmd[1:0]] : 8'h00;
    end

    // A command write with load set commits the staged byte once; the bit then just holds,
    // and each further command write with load set commits again, with no need to clear it first
    assign adc_commit = wr_en && (idx == cadr_pkg::IDX_CMD) && wbyte[cadr_pkg::CMD_LOAD_BIT]
        && (adc_mask(wbyte[5:0]) != 8'h00);
    assign dac2_commit = wr_en && (idx == cadr_pkg::IDX_DAC2_CMD)
        && wbyte[cadr_pkg::CMD_LOAD_BIT] && (dac2_mask(wbyte[5:0]) != 8'h00);

    // Level-control command and data registers
    always_comb begin
        next_cmd = cmd;
        next_data = data;
        if (wr_en && idx == cadr_pkg::IDX_CMD) begin
            next_cmd = wbyte;
        end
        if (wr_en && idx == cadr_pkg::IDX_DATA) begin
            next_data = wbyte;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd <= cadr_pkg::RST_ZERO;
            data <= cadr_pkg::RST_ZERO;
        end else if (clk_en) begin
            cmd <= next_cmd;
            data <= next_data;
        end
    end

    // Compressor command and data registers
    always_comb begin
        next_dcmd = dcmd;
        next_ddata = ddata;
        if (wr_en && idx == cadr_pkg::IDX_DAC2_CMD) begin
            next_dcmd = wbyte;
        end
        if (wr_en && idx == cadr_pkg::IDX_DAC2_DATA) begin
            next_ddata = wbyte;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dcmd <= cadr_pkg::RST_ZERO;
            ddata <= cadr_pkg::RST_ZERO;
        end else if (clk_en) begin
            dcmd <= next_dcmd;
            ddata <= next_ddata;
        end
    end

    // Test register: only the fast start-up bit is kept, the rest reads zero
    always_comb begin
        next_test = test;
        if (wr_en && idx == cadr_pkg::IDX_TEST) begin
            next_test = wbyte & cadr_pkg::M_TEST;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            test <= cadr_pkg::RST_ZERO;
        end else if (clk_en) begin
            test <= next_test;
        end
    end

    // Level-control indirect bank; the commit uses the data byte stored before the write
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            next_adc[i] = adc[i];
        end
        if (adc_commit) begin
            next_adc[wbyte[2:0]] = data & adc_mask(wbyte[5:0]);
        end
    end

    // Reset values give a usable level control before software touches it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            adc[0] <= cadr_pkg::RST_ADC_0;
            adc[1] <= cadr_pkg::RST_ADC_1;
            adc[2] <= cadr_pkg::RST_ADC_2;
            adc[3] <= cadr_pkg::RST_ADC_3;
            adc[4] <= cadr_pkg::RST_ZERO;
        end else if (clk_en) begin
            for (int i = 0; i < 5; i++) begin
                adc[i] <= next_adc[i];
            end
        end
    end

    // Compressor indirect bank, same load protocol as the level control
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            next_dac2[i] = dac2[i];
        end
        if (dac2_commit) begin
            next_dac2[wbyte[1:0]] = ddata & dac2_mask(wbyte[5:0]);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 4; i++) begin
                dac2[i] <= cadr_pkg::RST_ZERO;
            end
        end else if (clk_en) begin
            for (int i = 0; i < 4; i++) begin
                dac2[i] <= next_dac2[i];
            end
        end
    end

    // Bus answer: ready and error pulse for one cycle, read data holds until the next read
    always_comb begin
        next_pready = acc;
        next_pslverr = acc && !mapped;
        next_prdata = prdata;
        if (rd) begin
            next_prdata = 32'h0000_0000;
            case (idx)
                cadr_pkg::IDX_CMD: next_prdata[7:0] = cmd;
                // Load clear shows the addressed register, load set shows the staged byte
                cadr_pkg::IDX_DATA: next_prdata[7:0] =
                    cmd[cadr_pkg::CMD_LOAD_BIT] ? data : adc_sel;
                cadr_pkg::IDX_DAC2_CMD: next_prdata[7:0] = dcmd;
                cadr_pkg::IDX_DAC2_DATA: next_prdata[7:0] =
                    dcmd[cadr_pkg::CMD_LOAD_BIT] ? ddata : dac2_sel;
                cadr_pkg::IDX_TEST: next_prdata[7:0] = test;
                // Status registers and unmapped indexes read zero
                default: next_prdata[7:0] = 8'h00;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // Decoded settings toward the datapath
    always_comb begin
        next_left.threshold = dac2[0][4:0];
        next_left.ratio = dac2[1][2:0];
        // Coupled mode: right channel follows the left settings
        next_right.threshold = dac2[0][7] ? dac2[0][4:0] : dac2[2][4:0];
        next_right.ratio = dac2[0][7] ? dac2[1][2:0] : dac2[3][2:0];
        // Reserved ratio codes are clamped to the largest legal ratio
        if (next_left.ratio > cadr_pkg::RATIO_MAX) begin
            next_left.ratio = cadr_pkg::RATIO_MAX;
        end
        if (next_right.ratio > cadr_pkg::RATIO_MAX) begin
            next_right.ratio = cadr_pkg::RATIO_MAX;
        end
        next_ctrl.enable = cmd[cadr_pkg::CMD_EN_BIT];
        next_ctrl.target = adc[0][5:2];
        next_ctrl.gate_enable = adc[1][7];
        next_ctrl.gate_threshold = adc[1][6:4];
        next_ctrl.hold = adc[1][3:0];
        // Codes are per-step waits, passed raw to the step timer
        next_ctrl.ramp_down_interval = adc[2][7:4];
        next_ctrl.ramp_up_interval = adc[2][3:0];
        next_ctrl.upper_limit = adc[3][4:0];
        next_ctrl.lower_limit = adc[4][4:0];
        next_fast = test[cadr_pkg::TEST_FAST_BIT];
    end

    // Setting outputs trail the registers by one cycle so every output is a flip-flop;
    // clk_en low freezes them together with the rest of the bank
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dac2_left <= '0;
            dac2_right <= '0;
            adc_ctrl <= '0;
            fast_startup <= 1'b0;
        end else if (clk_en) begin
            dac2_left <= next_left;
            dac2_right <= next_right;
            adc_ctrl <= next_ctrl;
            fast_startup <= next_fast;
        end
    end
endmodule // cadr_regs

// File: sim/cadr_regs_chk.sv
// Port checker for the compressor and level-control register bank
`timescale 1ns/100ps
module cadr_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire cadr_pkg::cadr_comp_s dac2_left,
    input wire cadr_pkg::cadr_comp_s dac2_right
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic rd_done;
    logic [7:0] idx;
    // Read completion and the word index it addressed
    assign rd_done = psel && penable && pready && !pwrite;
    assign idx = paddr[9:2];
    a_one_wait: assert property (psel && penable && !pready |=> pready)
        else $error("access not answered after one wait state");
    a_ready_pulse: assert property (pready |=> !pready) else $error("ready held too long");
    a_ready_idle: assert property (!(psel && penable) |=> !pready)
        else $error("ready without an access");
    a_err_map: assert property (psel && penable && pready |->
        pslverr == !(idx inside {[8'h2F:8'h35], 8'h40, 8'h41})) else $error("error decode wrong");
    a_err_alone: assert property (pslverr |-> pready) else $error("error without ready");
    a_rd_upper: assert property (rd_done |-> prdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    a_rd_hold: assert property ($changed(prdata) |-> rd_done) else $error("read data moved");
    a_status_zero: assert property (rd_done && idx inside {[8'h31:8'h34]} |-> prdata == 0)
        else $error("status word not zero");
    a_ratio_cap: assert property (dac2_left.ratio <= 3'h5 && dac2_right.ratio <= 3'h5)
        else $error("ratio above top code");
    c_err: cover property (rd_done && pslverr);
    c_status: cover property (rd_done && idx == 8'h31);
    c_clamp: cover property (dac2_right.ratio == 3'h5);
endmodule // cadr_chk
bind cadr_regs cadr_chk cadr_chk_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dac2_left(dac2_left), .dac2_right(dac2_right));

// File: sim/cadr_regs_test.sv
// Self-checking bench for the compressor and level-control register bank
`timescale 1ns/100ps
module cadr_regs_test;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    cadr_pkg::cadr_comp_s dac2_left;
    cadr_pkg::cadr_comp_s dac2_right;
    cadr_pkg::cadr_agc_s adc_ctrl;
    logic fast_startup;
    logic agc_en = 1'b0;
    logic [32:0] expq[$];
    // Indirect register model, DAC2 bank first, with writable bits
    logic [7:0] mdl [2][5] = '{'{5{8'h00}}, '{8'h34, 8'h07, 8'h44, 8'h1F, 8'h00}};
    logic [7:0] msk [2][5] = '{'{8'h9F, 8'h07, 8'h1F, 8'h07, 8'h00},
        '{8'h3C, 8'hFF, 8'hFF, 8'h1F, 8'h1F}};
    integer seed = 32'hA39C0858;
    int n_mismatch = 0;
    int check_count = 0;

    cadr_regs cadr_regs_inst (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .dac2_left(dac2_left),
        .dac2_right(dac2_right), .adc_ctrl(adc_ctrl), .fast_startup(fast_startup));

    // 10 MHz clock
    initial forever #50 pclk = ~pclk;

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Oldest note against each completed read; data is a don't-care on error
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            cmp({pslverr, pslverr ? 32'h00000000 : prdata}, expq.pop_front());
        end
    end

    // One APB transfer; upper data bits and unused strobes are random
    task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d,
        input logic [32:0] e = 33'h0, input logic s = 1'b1);
        logic [31:0] r;
        r = $random(seed);
        if (!w) expq.push_back(e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, i, 2'b00};
        pwdata <= {r[31:8], d};
        pstrb <= {r[3:1], s};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Indirect write: data, address, load set, load cleared
    task automatic iwr(input int b, input logic [2:0] a, input logic [7:0] d);
        logic [7:0] c;
        logic [7:0] h;
        c = b ? 8'h2F : 8'h40;
        h = {b ? agc_en : 1'b0, 4'h0, a};
        apb(1'b1, c + 8'h01, d);
        apb(1'b1, c, h);
        apb(1'b1, c, h | 8'h40);
        apb(1'b1, c, h);
        mdl[b][a] = d & msk[b][a];
    endtask

    // Indirect read back with the load bit clear
    task automatic ird(input int b, input logic [2:0] a);
        logic [7:0] c;
        c = b ? 8'h2F : 8'h40;
        apb(1'b1, c, {b ? agc_en : 1'b0, 4'h0, a});
        apb(1'b0, c + 8'h01, 8'h00, {25'h0, mdl[b][a]});
    endtask

    // Ratio codes above the top one act as the top ratio
    function automatic logic [2:0] cl(input logic [2:0] x);
        return (x > 3'h5) ? 3'h5 : x;
    endfunction

    // Setting outputs trail the registers by one cycle, so wait two edges
    task automatic chk_out();
        logic [7:0] lft;
        logic [32:0] ex;
        lft = {mdl[0][0][4:0], cl(mdl[0][1][2:0])};
        ex = {2'b0, agc_en, mdl[1][0][5:2], mdl[1][1], mdl[1][2], mdl[1][3][4:0], mdl[1][4][4:0]};
        repeat (2) @(posedge pclk);
        cmp({25'h0, dac2_left}, {25'h0, lft});
        cmp({25'h0, dac2_right}, {25'h0, mdl[0][0][7] ? lft :
            {mdl[0][2][4:0], cl(mdl[0][3][2:0])}});
        cmp({2'b0, adc_ctrl}, ex);
    endtask

    // Main sequence
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        chk_out();
        for (int p = 0; p < 3; p++) begin
            agc_en = p[1];
            for (int b = 0; b < 2; b++) begin
                for (int a = 0; a < 5; a++) begin
                    if (p > 0) iwr(b, a[2:0], 8'($random(seed)));
                    ird(b, a[2:0]);
                end
            end
            chk_out();
        end
        iwr(0, 0, 8'hE5);
        iwr(0, 1, 8'hFE);
        iwr(0, 3, 8'h06);
        chk_out();
        iwr(0, 0, 8'h05);
        chk_out();
        apb(1'b1, 8'h31, 8'hFF);
        apb(1'b0, 8'h31, 8'h00, 33'h0);
        apb(1'b0, 8'h10, 8'h00, 33'h100000000);
        apb(1'b1, 8'h35, 8'hFF);
        apb(1'b1, 8'h35, 8'h00, 33'h0, 1'b0);
        apb(1'b0, 8'h35, 8'h00, 33'h80);
        repeat (2) @(posedge pclk);
        cmp({32'h0, fast_startup}, 33'h1);
        apb(1'b1, 8'h35, 8'h00);
        apb(1'b0, 8'h2F, 8'h00, {25'h0, agc_en, 1'b0, 6'h04});
        repeat (3) @(posedge pclk);
        end_of_test();
    end

    // Watchdog: the sequence needs well under two thousand cycles
    initial begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        end_of_test();
    end
endmodule // cadr_regs_test
